/* nas_pkg.sv */
// Package for the network address source selector: constants, modes and carriers.
// Assumes a single 100 MHz clock and classic Wishbone register access.
package nas_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BLINK_MS = 50;
	localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned ACT_HOLD_MS = 20;
	localparam int unsigned ACT_HOLD_CYC = CLK_HZ / 1000 * ACT_HOLD_MS;
	localparam int unsigned RING_MS = 100;
	localparam int unsigned RING_CYC = CLK_HZ / 1000 * RING_MS;

	localparam logic [31:0] DEF_IP = 32'hC0A801FE;
	localparam logic [31:0] DEF_MASK = 32'hFFFFFF00;
	localparam logic [31:0] DEF_GW = 32'hC0A80101;

	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IP = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_GW = 8'h0C;
	localparam logic [7:0] OFS_PRJ_IP = 8'h10;
	localparam logic [7:0] OFS_PRJ_MASK = 8'h14;
	localparam logic [7:0] OFS_PRJ_GW = 8'h18;
	localparam logic [7:0] OFS_SRV_IP = 8'h1C;
	localparam logic [7:0] OFS_SRV_MASK = 8'h20;
	localparam logic [7:0] OFS_SRV_GW = 8'h24;
	localparam logic [7:0] OFS_CTRL = 8'h28;
	localparam logic [7:0] OFS_NV_IP = 8'h2C;
	localparam logic [7:0] OFS_NV_MASK = 8'h30;
	localparam logic [7:0] OFS_NV_GW = 8'h34;

	localparam int CTRL_PRJ_COMMIT = 0;
	localparam int CTRL_SRV_DONE = 1;
	localparam int CTRL_NV_LOADED = 2;
	localparam int CTRL_NV_FLAG = 3;

	typedef enum logic [2:0] {
		NAS_SRC_DEFAULT = 3'b000,
		NAS_SRC_SWITCH = 3'b001,
		NAS_SRC_DHCP = 3'b010,
		NAS_SRC_BOOTP = 3'b011,
		NAS_SRC_STORED = 3'b100,
		NAS_SRC_ONCE = 3'b101,
		NAS_SRC_ERROR = 3'b110
	} nas_src_e;

	typedef enum logic [1:0] {
		NAS_ST_SAMPLE = 2'b00,
		NAS_ST_WAIT = 2'b01,
		NAS_ST_RUN = 2'b10
	} nas_state_e;

	typedef struct packed {
		logic [31:0] ip;
		logic [31:0] mask;
		logic [31:0] gw;
	} nas_addr_s;

	typedef struct packed {
		logic link;
		logic fast;
		logic activity;
	} nas_phy_s;

	typedef struct packed {
		logic yellow;
		logic green;
	} nas_led_s;
endpackage

/* nas_port_led.sv */
// Indicator driver for one Ethernet port: link/activity and speed lamps.
// Assumes phy status already synchronised and a shared blink enable pulse.
`timescale 1ns/1ps
module nas_port_led
	import nas_pkg::*;
#(
	parameter int unsigned HOLD_CYC = ACT_HOLD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic blink_en_i,
	input wire nas_phy_s phy_i,
	output nas_led_s led_o
);
	logic [31:0] hold_r;
	logic phase_r;
	wire busy = hold_r != 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_r <= 32'h0;
			phase_r <= 1'b0;
			led_o <= '0;
		end else begin
			// Activity stretched so short bursts still produce a visible flash.
			if (phy_i.activity && phy_i.link)
				hold_r <= HOLD_CYC;
			else if (busy)
				hold_r <= hold_r - 32'h1;
			if (blink_en_i)
				phase_r <= ~phase_r;
			led_o.yellow <= phy_i.link && (!busy || phase_r);
			led_o.green <= phy_i.link && phy_i.fast;
		end
	end
endmodule

/* nas_top.sv */
// Network address source selector: decodes the power-up switch bank, picks the address source,
// holds the active settings and drives both ports' lamps.
// Assumes pins from outside are asynchronous; software (firmware) uses classic Wishbone.
//
// Summary of operation
// - Yellow link/activity, green 100 Mbit lamps per port.
// - Speed follows the master automatically.
// - Switch bank sampled once after power-up.
// - Default address, mask and gateway constants.
// - Switches one to nine off restore defaults.
// - Mode off: switches give last address byte.
// - Last byte 0 or 255 is invalid.
// - Switch mode uses project upper bytes, mask, gateway.
// - Pattern one plus nine requests DHCP.
// - Pattern two plus nine requests BOOTP.
// - Pattern three plus nine loads stored values.
// - Pattern four plus nine: one-time DHCP kept.
// - Project download stores and applies immediately.
// - Ring use: keep checking both ports' traffic.
// - One-time mode checks stored flag first.
// - Any other mode clears the stored flag.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module nas_top
	import nas_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYC,
	parameter int unsigned RING_CYCLES = RING_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [9:0] dip_i,
	input wire nas_phy_s port_a_i,
	input wire nas_phy_s port_b_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output nas_led_s ethernet_port_a_o,
	output nas_led_s ethernet_port_b_o,
	output nas_src_e src_o,
	output logic addr_valid_o,
	output logic cfg_err_o,
	output logic server_req_o,
	output logic nv_write_o,
	output nas_addr_s active_o,
	output logic ring_fault_o
);
	logic [9:0] dip_m_r, dip_s_r;
	nas_phy_s pa_m_r, pa_s_r, pb_m_r, pb_s_r;
	nas_state_e state_r;
	nas_src_e src_r;
	logic [7:0] last_byte_r;
	nas_addr_s act_r, prj_r, srv_r, nv_r;
	logic nv_loaded_r, srv_done_r, nv_flag_r, prj_commit_r;
	logic [31:0] blink_cnt_r, ring_cnt_r;
	logic blink_en_r;
	logic seen_a_r, seen_b_r;

	// Switch decode uses synchronised copies only.
	wire mode_sw = dip_s_r[8];
	wire [3:0] sel4 = dip_s_r[3:0];
	wire [7:0] sw_byte = dip_s_r[7:0];
	wire all_off = dip_s_r[8:0] == 9'h000;
	wire byte_bad = sw_byte == 8'h00 || sw_byte == 8'hFF;

	function automatic nas_src_e decode_src(input logic off9, input logic mode, input logic [3:0] s,
		input logic bad);
		if (off9)
			return NAS_SRC_DEFAULT;
		if (!mode)
			return bad ? NAS_SRC_ERROR : NAS_SRC_SWITCH;
		case (s)
			4'h1: return NAS_SRC_DHCP;
			4'h2: return NAS_SRC_BOOTP;
			4'h4: return NAS_SRC_STORED;
			4'h8: return NAS_SRC_ONCE;
			default: return NAS_SRC_ERROR;
		endcase
	endfunction

	wire nas_src_e src_dec = decode_src(all_off, mode_sw, sel4, byte_bad);

	// Wishbone decode.
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire [7:0] ofs = wb_adr_i[7:0];
	// Unaligned or out-of-range words answer err instead of aliasing a register.
	wire ofs_hit = wb_adr_i[31:8] == 24'h0 && ofs[1:0] == 2'b00 && ofs <= OFS_NV_GW;
	wire wr = wb_req && wb_we_i && ofs_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	wire [31:0] ctrl_rd = {28'h0, nv_flag_r, nv_loaded_r, srv_done_r, prj_commit_r};
	wire [31:0] status_rd = {16'h0, last_byte_r, 1'b0, ring_fault_o, cfg_err_o, addr_valid_o,
		server_req_o, src_r};
	logic [31:0] rd_mux;
	always_comb begin
		case (ofs)
			OFS_STATUS: rd_mux = status_rd;
			OFS_IP: rd_mux = act_r.ip;
			OFS_MASK: rd_mux = act_r.mask;
			OFS_GW: rd_mux = act_r.gw;
			OFS_PRJ_IP: rd_mux = prj_r.ip;
			OFS_PRJ_MASK: rd_mux = prj_r.mask;
			OFS_PRJ_GW: rd_mux = prj_r.gw;
			OFS_SRV_IP: rd_mux = srv_r.ip;
			OFS_SRV_MASK: rd_mux = srv_r.mask;
			OFS_SRV_GW: rd_mux = srv_r.gw;
			OFS_CTRL: rd_mux = ctrl_rd;
			OFS_NV_IP: rd_mux = nv_r.ip;
			OFS_NV_MASK: rd_mux = nv_r.mask;
			OFS_NV_GW: rd_mux = nv_r.gw;
			default: rd_mux = 32'h0;
		endcase
	end

	wire ctrl_wr = wr && ofs == OFS_CTRL && wb_sel_i[0];
	wire commit_pulse = ctrl_wr && wb_dat_i[CTRL_PRJ_COMMIT];
	wire srv_pulse = ctrl_wr && wb_dat_i[CTRL_SRV_DONE];
	wire load_pulse = ctrl_wr && wb_dat_i[CTRL_NV_LOADED];

	// Only a waiting server request is answered; a stray done bit is dropped.
	wire srv_accept = server_req_o && srv_pulse;
	// Committed values and one-time server answers must also be what the next power-up finds in storage.
	wire store_prj = commit_pulse && state_r == NAS_ST_RUN;
	wire store_srv = srv_accept && src_r == NAS_SRC_ONCE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			// Unmapped addresses answer with err so software sees the fault.
			wb_ack_o <= wb_req && ofs_hit;
			wb_err_o <= wb_req && !ofs_hit;
			// Read data is zero outside an answer, so a stale word never looks valid.
			wb_dat_o <= (wb_req && !wb_we_i && ofs_hit) ? rd_mux : 32'h0;
		end
	end

	// Pin synchronisers.
	// Both stages reset, so the first decode never meets an unknown bank.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dip_m_r <= 10'h000;
			dip_s_r <= 10'h000;
			pa_m_r <= '0;
			pa_s_r <= '0;
			pb_m_r <= '0;
			pb_s_r <= '0;
		end else begin
			dip_m_r <= dip_i;
			dip_s_r <= dip_m_r;
			pa_m_r <= port_a_i;
			pa_s_r <= pa_m_r;
			pb_m_r <= port_b_i;
			pb_s_r <= pb_m_r;
		end
	end

	// Stored project values and the non-volatile image, written by firmware.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prj_r <= '0;
			srv_r <= '0;
			nv_r <= '0;
		end else begin
			if (wr) begin
				case (ofs)
					OFS_PRJ_IP: prj_r.ip <= merge(prj_r.ip, wb_dat_i, wb_sel_i);
					OFS_PRJ_MASK: prj_r.mask <= merge(prj_r.mask, wb_dat_i, wb_sel_i);
					OFS_PRJ_GW: prj_r.gw <= merge(prj_r.gw, wb_dat_i, wb_sel_i);
					OFS_SRV_IP: srv_r.ip <= merge(srv_r.ip, wb_dat_i, wb_sel_i);
					OFS_SRV_MASK: srv_r.mask <= merge(srv_r.mask, wb_dat_i, wb_sel_i);
					OFS_SRV_GW: srv_r.gw <= merge(srv_r.gw, wb_dat_i, wb_sel_i);
					OFS_NV_IP: nv_r.ip <= merge(nv_r.ip, wb_dat_i, wb_sel_i);
					OFS_NV_MASK: nv_r.mask <= merge(nv_r.mask, wb_dat_i, wb_sel_i);
					OFS_NV_GW: nv_r.gw <= merge(nv_r.gw, wb_dat_i, wb_sel_i);
					default: ;
				endcase
			end
			// The stored image takes a commit or a one-time server answer, so a power cycle keeps it.
			if (store_prj)
				nv_r <= prj_r;
			else if (store_srv)
				nv_r <= srv_r;
		end
	end

	// Power-up sequencer: three cycles after reset the synchronised bank is valid and frozen.
	logic [1:0] settle_r;
	// Decode also waits for the loaded image, so stored modes never read a blank one.
	wire settle_done = settle_r == 2'h3 && nv_loaded_r;
	wire flag_clear = src_r != NAS_SRC_ONCE && nv_flag_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= NAS_ST_SAMPLE;
			settle_r <= 2'h0;
			src_r <= NAS_SRC_DEFAULT;
			last_byte_r <= 8'h00;
			cfg_err_o <= 1'b0;
			server_req_o <= 1'b0;
			addr_valid_o <= 1'b0;
			nv_write_o <= 1'b0;
			nv_loaded_r <= 1'b0;
			srv_done_r <= 1'b0;
			prj_commit_r <= 1'b0;
			nv_flag_r <= 1'b0;
			act_r <= '0;
		end else begin
			nv_write_o <= 1'b0;
			if (load_pulse)
				nv_loaded_r <= 1'b1;
			if (load_pulse)
				nv_flag_r <= wb_dat_i[CTRL_NV_FLAG];
			case (state_r)
				NAS_ST_SAMPLE: begin
					settle_r <= settle_r + 2'h1;
					if (settle_done) begin
						src_r <= src_dec;
						last_byte_r <= sw_byte;
						cfg_err_o <= src_dec == NAS_SRC_ERROR;
						state_r <= NAS_ST_WAIT;
					end
				end
				NAS_ST_WAIT: begin
					state_r <= NAS_ST_RUN;
					case (src_r)
						NAS_SRC_SWITCH: begin
							act_r <= '{ip: {prj_r.ip[31:8], last_byte_r}, mask: prj_r.mask, gw: prj_r.gw};
							addr_valid_o <= 1'b1;
						end
						NAS_SRC_DHCP, NAS_SRC_BOOTP:
							server_req_o <= 1'b1;
						NAS_SRC_STORED: begin
							act_r <= nv_r;
							addr_valid_o <= 1'b1;
						end
						NAS_SRC_ONCE: begin
							if (nv_flag_r) begin
								act_r <= nv_r;
								addr_valid_o <= 1'b1;
							end else
								server_req_o <= 1'b1;
						end
						default: begin
							act_r <= '{ip: DEF_IP, mask: DEF_MASK, gw: DEF_GW};
							addr_valid_o <= 1'b1;
						end
					endcase
					// Leaving one-time mode forgets the flag, so a later return asks afresh.
					if (flag_clear) begin
						nv_flag_r <= 1'b0;
						nv_write_o <= 1'b1;
					end
				end
				NAS_ST_RUN: begin
					if (srv_accept) begin
						act_r <= srv_r;
						server_req_o <= 1'b0;
						srv_done_r <= 1'b1;
						addr_valid_o <= 1'b1;
						if (src_r == NAS_SRC_ONCE) begin
							nv_flag_r <= 1'b1;
							nv_write_o <= 1'b1;
						end
					end
					// A commit applies at once in any mode; the image follows it.
					if (commit_pulse) begin
						act_r <= prj_r;
						prj_commit_r <= 1'b1;
						addr_valid_o <= 1'b1;
						nv_write_o <= 1'b1;
					end
				end
				default: state_r <= NAS_ST_SAMPLE;
			endcase
		end
	end

	// Source and settings leave straight from their registers.
	always_comb src_o = src_r;
	always_comb active_o = act_r;

	wire blink_end = blink_cnt_r == BLINK_CYCLES - 1;
	wire ring_end = ring_cnt_r == RING_CYCLES - 1;

	// Blink enable and ring supervision share one slow divider style.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_r <= 32'h0;
			blink_en_r <= 1'b0;
			ring_cnt_r <= 32'h0;
			seen_a_r <= 1'b0;
			seen_b_r <= 1'b0;
			ring_fault_o <= 1'b0;
		end else begin
			blink_en_r <= blink_end;
			blink_cnt_r <= blink_end ? 32'h0 : blink_cnt_r + 32'h1;
			if (ring_end) begin
				// A window with traffic on only one port means the ring path is not served.
				ring_fault_o <= (seen_a_r || seen_b_r) && !(seen_a_r && seen_b_r);
				ring_cnt_r <= 32'h0;
				seen_a_r <= pa_s_r.activity;
				seen_b_r <= pb_s_r.activity;
			end else begin
				ring_cnt_r <= ring_cnt_r + 32'h1;
				seen_a_r <= seen_a_r || pa_s_r.activity;
				seen_b_r <= seen_b_r || pb_s_r.activity;
			end
		end
	end

	nas_port_led u_led_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.blink_en_i(blink_en_r),
		.phy_i(pa_s_r),
		.led_o(ethernet_port_a_o)
	);

	nas_port_led u_led_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.blink_en_i(blink_en_r),
		.phy_i(pb_s_r),
		.led_o(ethernet_port_b_o)
	);
endmodule

/* nas_top_properties.sv */
// Checker for the address source selector, watching only top-level ports.
// Assumes it is bound to nas_top by the bench.
`timescale 1ns/1ps
module nas_top_properties
	import nas_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire nas_phy_s port_a_i,
	input wire nas_phy_s port_b_i,
	input wire nas_led_s ethernet_port_a_o,
	input wire nas_led_s ethernet_port_b_o,
	input wire nas_src_e src_o,
	input wire logic addr_valid_o,
	input wire logic cfg_err_o,
	input wire logic server_req_o,
	input wire logic nv_write_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	// Five samples cover the synchroniser and lamp register latency.
	sequence s_fast_a;
		(port_a_i.link && port_a_i.fast)[*5];
	endsequence
	sequence s_dark_b;
		(!port_b_i.link)[*5];
	endsequence
	property p_answer;
		s_req |=> (wb_ack_o ^ wb_err_o);
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_green_a;
		s_fast_a |-> ethernet_port_a_o.green;
	endproperty
	property p_dark_b;
		s_dark_b |-> ethernet_port_b_o == 2'h0;
	endproperty
	property p_src_hold;
		src_o != NAS_SRC_DEFAULT |=> $stable(src_o);
	endproperty
	property p_err_flag;
		src_o == NAS_SRC_ERROR && $past(src_o) == NAS_SRC_ERROR |-> cfg_err_o;
	endproperty
	property p_req_src;
		server_req_o |-> src_o inside {NAS_SRC_DHCP, NAS_SRC_BOOTP, NAS_SRC_ONCE} && !addr_valid_o;
	endproperty
	property p_nv_pulse;
		nv_write_o |=> !nv_write_o;
	endproperty
	a_answer: assert property (p_answer) else $error("bus request not answered");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_green_a: assert property (p_green_a) else $error("fast link lamp off");
	a_dark_b: assert property (p_dark_b) else $error("lamps lit without link");
	a_src_hold: assert property (p_src_hold) else $error("source changed after decode");
	a_err_flag: assert property (p_err_flag) else $error("error source without flag");
	a_req_src: assert property (p_req_src) else $error("server request in wrong mode");
	a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
endmodule

/* nas_phy_model.sv */
// Far-side link model for both ports: link, rate and traffic.
// Assumes the bench picks each port's state; traffic toggles every cycle.
`timescale 1ns/1ps
module nas_phy_model
	import nas_pkg::*;
(
	input wire logic clk_i,
	input wire logic [1:0] mode_a_i,
	input wire logic [1:0] mode_b_i,
	output nas_phy_s port_a_o,
	output nas_phy_s port_b_o
);
	logic tgl_r = 1'b0;
	always_ff @(posedge clk_i) begin
		tgl_r <= ~tgl_r;
	end
	// Modes: 0 no link, 1 slow link, 2 fast link, 3 fast link with traffic.
	assign port_a_o = {mode_a_i != 2'h0, mode_a_i[1], (&mode_a_i) & tgl_r};
	assign port_b_o = {mode_b_i != 2'h0, mode_b_i[1], (&mode_b_i) & tgl_r};
endmodule

/* network_address_source_select_tb.sv */
// Self-checking bench for the address source selector.
// Assumes the phy model on the ports and this bench as firmware on the bus.
`timescale 1ns/1ps
module network_address_source_select_tb
	import nas_pkg::*;
;
	typedef struct packed {logic [9:0] dip; logic f; nas_src_e src; logic ce; logic rq; logic va; nas_addr_s a;} nas_row_s;
	localparam nas_addr_s DEF = {DEF_IP, DEF_MASK, DEF_GW};
	localparam nas_addr_s PRJ = {32'h0A000105, 32'hFFFF0000, 32'h0A000001};
	localparam nas_addr_s NVV = {32'hAC100A07, 32'hFFFFFFF0, 32'hAC100A01};
	localparam nas_addr_s SRV = {32'h0A0B0C0D, 32'hFFFFFF80, 32'h0A0B0C01};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] dip_i = 10'h000;
	nas_phy_s port_a_i;
	nas_phy_s port_b_i;
	logic [1:0] mode_a = 2'h0;
	logic [1:0] mode_b = 2'h0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, wb_err_o, addr_valid_o, cfg_err_o, server_req_o, nv_write_o, ring_fault_o;
	nas_led_s ethernet_port_a_o, ethernet_port_b_o;
	nas_src_e src_o;
	nas_addr_s active_o;
	logic [31:0] rq;
	logic re;
	int err_total = 0;
	int num_checks = 0;
	int nv_cnt = 0;
	int n;
	nas_row_s rows [0:10] = '{
		'{10'h200, 1'b0, NAS_SRC_DEFAULT, 1'b0, 1'b0, 1'b1, DEF},
		'{10'h012, 1'b0, NAS_SRC_SWITCH, 1'b0, 1'b0, 1'b1, {PRJ[95:72], 8'h12, PRJ[63:0]}},
		'{10'h001, 1'b0, NAS_SRC_SWITCH, 1'b0, 1'b0, 1'b1, {PRJ[95:72], 8'h01, PRJ[63:0]}},
		'{10'h2FE, 1'b0, NAS_SRC_SWITCH, 1'b0, 1'b0, 1'b1, {PRJ[95:72], 8'hFE, PRJ[63:0]}},
		'{10'h0FF, 1'b0, NAS_SRC_ERROR, 1'b1, 1'b0, 1'b1, DEF},
		'{10'h101, 1'b0, NAS_SRC_DHCP, 1'b0, 1'b1, 1'b0, DEF},
		'{10'h1F2, 1'b0, NAS_SRC_BOOTP, 1'b0, 1'b1, 1'b0, DEF},
		'{10'h304, 1'b1, NAS_SRC_STORED, 1'b0, 1'b0, 1'b1, NVV},
		'{10'h108, 1'b1, NAS_SRC_ONCE, 1'b0, 1'b0, 1'b1, NVV},
		'{10'h108, 1'b0, NAS_SRC_ONCE, 1'b0, 1'b1, 1'b0, DEF},
		'{10'h103, 1'b0, NAS_SRC_ERROR, 1'b1, 1'b0, 1'b1, DEF}};
	nas_top #(.BLINK_CYCLES(8), .RING_CYCLES(32)) u_nas_top (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.dip_i(dip_i),
		.port_a_i(port_a_i),
		.port_b_i(port_b_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o),
		.ethernet_port_a_o(ethernet_port_a_o),
		.ethernet_port_b_o(ethernet_port_b_o),
		.src_o(src_o),
		.addr_valid_o(addr_valid_o),
		.cfg_err_o(cfg_err_o),
		.server_req_o(server_req_o),
		.nv_write_o(nv_write_o),
		.active_o(active_o),
		.ring_fault_o(ring_fault_o)
	);
	nas_phy_model u_nas_phy_model (.clk_i(clk_i), .mode_a_i(mode_a), .mode_b_i(mode_b), .port_a_o(port_a_i),
		.port_b_o(port_b_i));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (nv_write_o === 1'b1)
			nv_cnt <= nv_cnt + 1;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [127:0] g, input logic [127:0] x);
		num_checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {24'h0, a};
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rq = wb_dat_o;
		re = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic put(input logic [7:0] b, input nas_addr_s v);
		for (int i = 0; i < 3; i++)
			wb(1'b1, b + 8'(4 * i), v[95 - 32 * i -: 32]);
	endtask
	task automatic boot(input logic [9:0] d, input logic f);
		rst_i <= 1'b1;
		dip_i <= d;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		nv_cnt = 0;
		put(OFS_NV_IP, NVV);
		put(OFS_PRJ_IP, PRJ);
		wb(1'b1, OFS_CTRL, {28'h0, f, 3'h4});
		repeat (6) @(posedge clk_i);
	endtask
	task automatic srv();
		nv_cnt = 0;
		put(OFS_SRV_IP, SRV);
		wb(1'b1, OFS_CTRL, 32'h2);
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		for (int i = 0; i < 11; i++) begin
			boot(rows[i].dip, rows[i].f);
			chk("source", src_o, rows[i].src);
			chk("cfg_err", cfg_err_o, rows[i].ce);
			chk("server_req", server_req_o, rows[i].rq);
			chk("addr_valid", addr_valid_o, rows[i].va);
			if (rows[i].va)
				chk("active", active_o, rows[i].a);
		end
		boot(10'h012, 1'b0);
		dip_i <= 10'h101;
		repeat (10) @(posedge clk_i);
		chk("frozen", src_o, NAS_SRC_SWITCH);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("status", rq[2:0], 3'h1);
		wb(1'b0, 8'h38, 32'h0);
		chk("unmapped", {re, rq}, {1'b1, 32'h0});
		boot(10'h101, 1'b1);
		wb(1'b0, OFS_CTRL, 32'h0);
		chk("flag_clear", {nv_cnt > 0, rq[3]}, 2'b10);
		srv();
		chk("served", {server_req_o, addr_valid_o, active_o}, {2'b01, SRV});
		boot(10'h108, 1'b0);
		srv();
		chk("flag_set", {nv_cnt > 0, active_o}, {1'b1, SRV});
		wb(1'b0, OFS_NV_IP, 32'h0);
		chk("once_kept", rq, SRV[95:64]);
		boot(10'h104, 1'b1);
		put(OFS_PRJ_IP, SRV);
		wb(1'b1, OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("commit", active_o, SRV);
		wb(1'b0, OFS_NV_IP, 32'h0);
		chk("commit_stored", rq, SRV[95:64]);
		mode_a <= 2'h2;
		mode_b <= 2'h1;
		repeat (8) @(posedge clk_i);
		chk("lamps_a", {ethernet_port_a_o, ethernet_port_b_o}, 4'hE);
		mode_a <= 2'h0;
		mode_b <= 2'h3;
		n = 0;
		repeat (40) begin
			@(posedge clk_i);
			if (ethernet_port_b_o.yellow === 1'b0)
				n++;
		end
		chk("lamps_b", {ethernet_port_a_o, ethernet_port_b_o.green, n > 0}, 4'h3);
		repeat (40) @(posedge clk_i);
		chk("ring_one", ring_fault_o, 1'b1);
		mode_a <= 2'h3;
		repeat (80) @(posedge clk_i);
		chk("ring_both", ring_fault_o, 1'b0);
		report_and_stop();
	end
	initial begin
		#300000;
		err_total++;
		report_and_stop();
	end
endmodule
bind nas_top nas_top_properties u_nas_top_properties (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o),
	.port_a_i(port_a_i),
	.port_b_i(port_b_i),
	.ethernet_port_a_o(ethernet_port_a_o),
	.ethernet_port_b_o(ethernet_port_b_o),
	.src_o(src_o),
	.addr_valid_o(addr_valid_o),
	.cfg_err_o(cfg_err_o),
	.server_req_o(server_req_o),
	.nv_write_o(nv_write_o)
);
